// ===== hw/adof_pkg.sv
// constants shared by the converter output formatter
package adof_pkg;
	localparam int unsigned DATA_W          = 14;
	localparam int unsigned PAIRS           = 7;
	localparam int unsigned NAP_WAKE_CYCLES = 100;
	// register indices; byte address is four times the index
	localparam logic [9:0]  IDX_POWER_DOWN  = 10'h001;
	localparam logic [9:0]  IDX_TIMING      = 10'h002;
	localparam logic [9:0]  IDX_OUTPUT_MODE = 10'h003;
	localparam logic [9:0]  IDX_DATA_FORMAT = 10'h004;
	localparam logic [9:0]  IDX_STATUS      = 10'h005;
	localparam logic [7:0]  REG_RESET       = 8'h00;
	// power_down_reg fields
	localparam int unsigned SLEEP_BIT       = 3;
	localparam int unsigned NAP_BIT         = 2;
	// timing_reg fields
	localparam int unsigned INV_BIT         = 3;
	localparam int unsigned PHASE_LSB       = 1;
	localparam int unsigned DCS_BIT         = 0;
	// output_mode_reg fields
	localparam int unsigned ILVDS_LSB       = 2;
	localparam int unsigned TERM_BIT        = 1;
	localparam int unsigned OFF_BIT         = 0;
	// data_format_reg fields
	localparam int unsigned TEST_LSB        = 5;
	localparam int unsigned ABP_BIT         = 4;
	localparam int unsigned DTEST_BIT       = 2;
	localparam int unsigned RAND_BIT        = 1;
	localparam int unsigned TWOS_BIT        = 0;
	// drive current codes and levels, units of 0.05 mA
	localparam logic [2:0]  ILVDS_3P5       = 3'h0;
	localparam logic [2:0]  ILVDS_4P0       = 3'h1;
	localparam logic [2:0]  ILVDS_4P5       = 3'h2;
	localparam logic [2:0]  ILVDS_3P0       = 3'h4;
	localparam logic [2:0]  ILVDS_2P5       = 3'h5;
	localparam logic [2:0]  ILVDS_2P1       = 3'h6;
	localparam logic [2:0]  ILVDS_1P75      = 3'h7;
	localparam logic [7:0]  CUR_3P5         = 8'h46;
	localparam logic [7:0]  CUR_4P0         = 8'h50;
	localparam logic [7:0]  CUR_4P5         = 8'h5A;
	localparam logic [7:0]  CUR_3P0         = 8'h3C;
	localparam logic [7:0]  CUR_2P5         = 8'h32;
	localparam logic [7:0]  CUR_2P1         = 8'h2A;
	localparam logic [7:0]  CUR_1P75        = 8'h23;
	// test pattern selections
	localparam logic [2:0]  TP_ZERO         = 3'h0;
	localparam logic [2:0]  TP_ONE          = 3'h1;
	localparam logic [2:0]  TP_CHECK        = 3'h2;
	localparam logic [2:0]  TP_ALT          = 3'h3;
	// data codes
	localparam logic [13:0] FULL_POS        = 14'h3FFF;
	localparam logic [13:0] FULL_NEG        = 14'h0000;
	localparam logic [13:0] MSB_MASK        = 14'h2000;
	localparam logic [13:0] ODD_MASK        = 14'h2AAA;
	localparam logic [13:0] CHECK_A         = 14'h1555;
	localparam logic [13:0] CHECK_B         = 14'h2AAA;
	// phase delay in eighths of the encode period
	localparam int unsigned PHASE_SHIFT     = 3;
	localparam logic [1:0]  RESP_OKAY       = 2'h0;
	localparam logic [1:0]  RESP_DECERR     = 2'h3;
endpackage

// ===== hw/adof_ddr_tx.sv
// double data rate output stage with shared output enable
`timescale 1ns/1ps
`default_nettype none
module adof_ddr_tx #(
	parameter int unsigned PAIRS = adof_pkg::PAIRS
) (
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire logic [2*PAIRS-1:0] word,
	input  wire logic               flag,
	input  wire logic               hi_half,
	input  wire logic               clk_in,
	input  wire logic               out_off,
	output logic      [PAIRS-1:0]   pair_data,
	output logic                    pair_oe,
	output logic                    flag_out,
	output logic                    flag_oe,
	output logic                    clk_out,
	output logic                    clk_oe
);
	logic oe_ff;
	logic flag_ff;
	logic clk_ff;

	genvar i;
	generate
		for (i = 0; i < PAIRS; i++) begin : g_pair
			// even bit low half, odd bit high
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					pair_data[i] <= 1'b0;
				end else begin
					pair_data[i] <= hi_half ? word[2*i+1] : word[2*i];
				end
			end
		end
	endgenerate

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			oe_ff   <= 1'b0;
			flag_ff <= 1'b0;
			clk_ff  <= 1'b0;
		end else begin
			oe_ff   <= !out_off;
			flag_ff <= hi_half ? 1'b0 : flag;
			clk_ff  <= clk_in;
		end
	end

	assign pair_oe  = oe_ff;
	assign flag_oe  = oe_ff;
	assign clk_oe   = oe_ff;
	assign flag_out = flag_ff;
	assign clk_out  = clk_ff;
endmodule
`default_nettype wire

// ===== hw/adof_top.sv
// converter output formatter with register slave
// Overview of operation
// - stabilizer regenerates 50% clock from rising edges
// - seven ddr pairs plus flag and clock
// - even bits low half, odd bits high
// - drive current default 3.5mA, seven levels
// - internal termination doubles drive current
// - out of range sets flag, saturates
// - flag shares data pipeline latency
// - flag valid in clock low phase
// - clock delayed 0/45/90/135 degrees when the stabilizer is on
// - separate invert flips forwarded clock
// - offset binary default, twos inverts msb
// - randomizer xors upper bits with lsb
// - alternate polarity inverts odd data bits
// - randomizer and polarity independently enabled
// - four test patterns on flag, data
// - test pattern overrides all formatting
// - output disable tristates every pair
// - sleep by register bit or pin
// - data resumes 100 cycles after nap
`timescale 1ns/1ps
`default_nettype none
module adof_top #(
	parameter int unsigned LATENCY  = 1,
	parameter int unsigned NAP_WAKE = adof_pkg::NAP_WAKE_CYCLES
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        enc_clk,
	input  wire logic [13:0] sample_code,
	input  wire logic        sample_over,
	input  wire logic        sample_under,
	input  wire logic        par_mode_sel,
	input  wire logic        par_dcs_sel,
	input  wire logic        par_sleep_sel,
	input  wire logic        par_low_current_sel,
	output logic [6:0]       ddr_pair_data,
	output logic             ddr_pair_oe,
	output logic             range_flag,
	output logic             range_flag_oe,
	output logic             forwarded_out_clock,
	output logic             forwarded_out_clock_oe,
	output logic             dcs_enable,
	output logic             sleep_active,
	output logic             nap_active,
	output logic [7:0]       drive_current,
	output logic             term_enable,
	output logic             data_settled
);
	localparam int unsigned SW = 21;

	// pin synchronisers
	logic [SW-1:0] sync1_ff;
	logic [SW-1:0] sync2_ff;
	wire  [SW-1:0] sync_in = {par_mode_sel, par_dcs_sel, par_sleep_sel, par_low_current_sel,
		enc_clk, sample_over, sample_under, sample_code};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= sync_in;
			sync2_ff <= sync1_ff;
		end
	end

	wire [13:0] code_s   = sync2_ff[13:0];
	wire        under_s  = sync2_ff[14];
	wire        over_s   = sync2_ff[15];
	wire        enc_s    = sync2_ff[16];
	wire        par_mode = sync2_ff[20];

	// configuration registers
	logic [7:0] pwr_ff;
	logic [7:0] tim_ff;
	logic [7:0] omode_ff;
	logic [7:0] dfmt_ff;

	// sleep from register or parallel pin
	wire       cfg_sleep = par_mode ? sync2_ff[18] : pwr_ff[adof_pkg::SLEEP_BIT];
	wire       cfg_nap   = !par_mode && pwr_ff[adof_pkg::NAP_BIT];
	wire       cfg_dcs   = par_mode ? sync2_ff[19] : tim_ff[adof_pkg::DCS_BIT];
	wire       cfg_inv   = !par_mode && tim_ff[adof_pkg::INV_BIT];
	wire [1:0] cfg_phase = par_mode ? 2'h0 : tim_ff[adof_pkg::PHASE_LSB +: 2];
	wire       cfg_off   = !par_mode && omode_ff[adof_pkg::OFF_BIT];
	wire       cfg_term  = !par_mode && omode_ff[adof_pkg::TERM_BIT];
	wire [2:0] cfg_ilvds = par_mode ? (sync2_ff[17] ? adof_pkg::ILVDS_1P75 : adof_pkg::ILVDS_3P5)
		: omode_ff[adof_pkg::ILVDS_LSB +: 3];
	wire       cfg_twos  = !par_mode && dfmt_ff[adof_pkg::TWOS_BIT];
	wire       cfg_rand  = !par_mode && dfmt_ff[adof_pkg::RAND_BIT];
	wire       cfg_abp   = !par_mode && dfmt_ff[adof_pkg::ABP_BIT];
	wire       cfg_test  = !par_mode && dfmt_ff[adof_pkg::DTEST_BIT];
	wire [2:0] cfg_tp    = dfmt_ff[adof_pkg::TEST_LSB +: 3];

	// drive current lookup
	logic [7:0] drive_base;
	// seven levels, unused code keeps default
	always_comb begin
		case (cfg_ilvds)
			adof_pkg::ILVDS_4P0:  drive_base = adof_pkg::CUR_4P0;
			adof_pkg::ILVDS_4P5:  drive_base = adof_pkg::CUR_4P5;
			adof_pkg::ILVDS_3P0:  drive_base = adof_pkg::CUR_3P0;
			adof_pkg::ILVDS_2P5:  drive_base = adof_pkg::CUR_2P5;
			adof_pkg::ILVDS_2P1:  drive_base = adof_pkg::CUR_2P1;
			adof_pkg::ILVDS_1P75: drive_base = adof_pkg::CUR_1P75;
			default:              drive_base = adof_pkg::CUR_3P5;
		endcase
	end
	assign drive_current = cfg_term ? {drive_base[6:0], 1'b0} : drive_base;
	assign term_enable   = cfg_term;
	assign dcs_enable    = cfg_dcs;
	assign sleep_active  = cfg_sleep;
	assign nap_active    = cfg_nap;

	// encode edge tracking and period measure
	logic       enc_d_ff;
	logic [7:0] cnt_ff;
	logic [7:0] period_ff;
	wire        enc_rise = enc_s && !enc_d_ff;
	wire  [7:0] half     = {1'b0, period_ff[7:1]};
	wire  [9:0] dly_prod = {2'b00, period_ff} * {8'h00, cfg_phase};
	wire  [7:0] dly      = {1'b0, dly_prod[9:3]};
	wire  [7:0] shifted  = (cnt_ff >= dly) ? cnt_ff - dly : cnt_ff + period_ff - dly;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			enc_d_ff  <= 1'b0;
			cnt_ff    <= 8'h00;
			period_ff <= 8'h00;
		end else begin
			enc_d_ff <= enc_s;
			if (enc_rise) begin
				cnt_ff    <= 8'h00;
				period_ff <= cnt_ff + 8'h01;
			end else if (cnt_ff != 8'hFF) begin
				cnt_ff <= cnt_ff + 8'h01;
			end
		end
	end

	// stabilizer: halves from measured period, not input duty
	wire hi_half  = cfg_dcs ? (cnt_ff >= half) : !enc_d_ff;
	// phase delay needs the stabilizer's counter
	wire clk_base = cfg_dcs ? (shifted >= half) : !enc_d_ff;
	wire clk_fwd  = !cfg_sleep && (clk_base ^ cfg_inv);

	// formatting chain
	// saturate and flag out of range
	wire [13:0] sat_code = over_s ? adof_pkg::FULL_POS : (under_s ? adof_pkg::FULL_NEG : code_s);
	wire        fmt_flag = over_s || under_s;
	wire [13:0] fmt1     = cfg_twos ? sat_code ^ adof_pkg::MSB_MASK : sat_code;
	wire [13:0] fmt2     = cfg_rand ? fmt1 ^ {{13{fmt1[0]}}, 1'b0} : fmt1;
	// odd bits inverted, after randomizer, own enable
	wire [13:0] fmt3     = cfg_abp ? fmt2 ^ adof_pkg::ODD_MASK : fmt2;

	logic        alt_ff;
	logic [14:0] tp_word;
	always_comb begin
		case (cfg_tp)
			adof_pkg::TP_ONE:   tp_word = {1'b1, adof_pkg::FULL_POS};
			adof_pkg::TP_CHECK: tp_word = alt_ff ? {1'b0, adof_pkg::CHECK_B} : {1'b1, adof_pkg::CHECK_A};
			adof_pkg::TP_ALT:   tp_word = alt_ff ? 15'h0000 : 15'h7FFF;
			default:            tp_word = 15'h0000;
		endcase
	end

	// nap and sleep wake counting
	logic [7:0] wake_ff;
	logic       settled_ff;
	wire        quiet    = cfg_nap || cfg_sleep;
	wire [14:0] nxt_word = cfg_test ? tp_word : (settled_ff ? {fmt_flag, fmt3} : 15'h0000);

	// hold data for the wake count
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wake_ff    <= 8'h00;
			settled_ff <= 1'b1;
		end else if (quiet) begin
			wake_ff    <= 8'h00;
			settled_ff <= 1'b0;
		end else if (enc_rise && !settled_ff) begin
			wake_ff    <= wake_ff + 8'h01;
			settled_ff <= (wake_ff == 8'(NAP_WAKE - 1));
		end
	end
	assign data_settled = settled_ff;

	// flag travels with its data word
	logic [14:0] pipe_ff [LATENCY];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			alt_ff <= 1'b0;
			for (int k = 0; k < LATENCY; k++) begin
				pipe_ff[k] <= 15'h0000;
			end
		end else if (enc_rise && !cfg_sleep) begin
			alt_ff     <= !alt_ff;
			pipe_ff[0] <= nxt_word;
			for (int k = 1; k < LATENCY; k++) begin
				pipe_ff[k] <= pipe_ff[k-1];
			end
		end
	end
	wire [14:0] out_word = pipe_ff[LATENCY-1];

	// seven pairs plus flag and clock
	adof_ddr_tx #(
		.PAIRS(adof_pkg::PAIRS)
	) u_tx (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.word      (out_word[13:0]),
		.flag      (out_word[14]),
		.hi_half   (hi_half),
		.clk_in    (clk_fwd),
		.out_off   (cfg_off),
		.pair_data (ddr_pair_data),
		.pair_oe   (ddr_pair_oe),
		.flag_out  (range_flag),
		.flag_oe   (range_flag_oe),
		.clk_out   (forwarded_out_clock),
		.clk_oe    (forwarded_out_clock_oe)
	);

	// register slave, write side
	logic        aw_full_ff;
	logic        w_full_ff;
	logic        bvalid_ff;
	logic [9:0]  wr_idx_ff;
	logic [7:0]  wdata_ff;
	logic        wstrb_ff;
	logic [1:0]  bresp_ff;
	wire         wr_go   = aw_full_ff && w_full_ff && !bvalid_ff;
	wire         wr_en   = wr_go && wstrb_ff;
	wire         hit_pwr = wr_idx_ff == adof_pkg::IDX_POWER_DOWN;
	wire         hit_tim = wr_idx_ff == adof_pkg::IDX_TIMING;
	wire         hit_om  = wr_idx_ff == adof_pkg::IDX_OUTPUT_MODE;
	wire         hit_df  = wr_idx_ff == adof_pkg::IDX_DATA_FORMAT;
	wire         hit_st  = wr_idx_ff == adof_pkg::IDX_STATUS;
	wire         wr_map  = hit_pwr || hit_tim || hit_om || hit_df || hit_st;

	assign s_axi_awready = !aw_full_ff && !bvalid_ff;
	assign s_axi_wready  = !w_full_ff && !bvalid_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_ff <= 1'b0;
			w_full_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
			wr_idx_ff  <= 10'h000;
			wdata_ff   <= 8'h00;
			wstrb_ff   <= 1'b0;
			bresp_ff   <= adof_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_ff <= 1'b1;
				wr_idx_ff  <= s_axi_awaddr[11:2];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_ff <= 1'b1;
				wdata_ff  <= s_axi_wdata[7:0];
				wstrb_ff  <= s_axi_wstrb[0];
			end
			if (wr_go) begin
				aw_full_ff <= 1'b0;
				w_full_ff  <= 1'b0;
				bvalid_ff  <= 1'b1;
				bresp_ff   <= wr_map ? adof_pkg::RESP_OKAY : adof_pkg::RESP_DECERR;
			end else if (bvalid_ff && s_axi_bready) begin
				bvalid_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pwr_ff   <= adof_pkg::REG_RESET;
			tim_ff   <= adof_pkg::REG_RESET;
			omode_ff <= adof_pkg::REG_RESET;
			dfmt_ff  <= adof_pkg::REG_RESET;
		end else begin
			if (wr_en && hit_pwr) pwr_ff <= wdata_ff;
			if (wr_en && hit_tim) tim_ff <= wdata_ff;
			if (wr_en && hit_om) omode_ff <= wdata_ff;
			if (wr_en && hit_df) dfmt_ff <= wdata_ff;
		end
	end

	// register slave, read side
	logic        rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0]  rresp_ff;
	logic [31:0] rd_word;
	logic        rd_ok;
	wire  [9:0]  rd_idx = s_axi_araddr[11:2];

	always_comb begin
		rd_ok = 1'b1;
		case (rd_idx)
			adof_pkg::IDX_POWER_DOWN:  rd_word = {24'h000000, pwr_ff};
			adof_pkg::IDX_TIMING:      rd_word = {24'h000000, tim_ff};
			adof_pkg::IDX_OUTPUT_MODE: rd_word = {24'h000000, omode_ff};
			adof_pkg::IDX_DATA_FORMAT: rd_word = {24'h000000, dfmt_ff};
			adof_pkg::IDX_STATUS:      rd_word = {16'h0000, period_ff, 4'h0,
				settled_ff, cfg_nap, cfg_sleep, par_mode};
			default: begin
				rd_word = 32'h00000000;
				rd_ok   = 1'b0;
			end
		endcase
	end

	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h00000000;
			rresp_ff  <= adof_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= rd_word;
			rresp_ff  <= rd_ok ? adof_pkg::RESP_OKAY : adof_pkg::RESP_DECERR;
		end else if (rvalid_ff && s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// checks
	default clocking dc @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence off_held_s;
		cfg_off ##1 cfg_off;
	endsequence
	sequence nap_exit_s;
		cfg_nap ##1 !cfg_nap && !cfg_sleep;
	endsequence

	sat_over_a: assert property (over_s |-> fmt_flag && sat_code == adof_pkg::FULL_POS)
		else $error("over range not saturated");
	twos_msb_a: assert property ((fmt1 ^ sat_code) == (cfg_twos ? adof_pkg::MSB_MASK : 14'h0000))
		else $error("twos complement wrong");
	rand_lsb_a: assert property (cfg_rand |-> (fmt2 ^ fmt1) == {{13{fmt1[0]}}, 1'b0})
		else $error("randomizer wrong");
	abp_odd_a: assert property ((fmt3 ^ fmt2) == (cfg_abp ? adof_pkg::ODD_MASK : 14'h0000))
		else $error("odd bit inversion wrong");
	test_over_a: assert property (cfg_test && cfg_tp == adof_pkg::TP_ONE |-> nxt_word == 15'h7FFF)
		else $error("test pattern not overriding");
	out_off_a: assert property (off_held_s |-> !ddr_pair_oe && !range_flag_oe && !forwarded_out_clock_oe)
		else $error("outputs driven while disabled");
	flag_low_a: assert property (hi_half |=> !range_flag)
		else $error("flag driven in high half");
	nap_hold_a: assert property (nap_exit_s |-> !data_settled [*8])
		else $error("data resumed early after nap");
	term_dbl_a: assert property (cfg_term |-> drive_current == {drive_base[6:0], 1'b0})
		else $error("termination current not doubled");
	clk_align_a: assert property (cfg_dcs && cfg_phase == 2'h0 && !cfg_inv && !cfg_sleep |=>
		forwarded_out_clock == $past(hi_half))
		else $error("clock not aligned with data halves");
	pair_even_a: assert property (!hi_half |=> ddr_pair_data[0] == $past(out_word[0]))
		else $error("even bit not in low half");
endmodule
`default_nettype wire

// ===== verif/adof_rx_model.sv
// receiving capture model for the ddr output link
`timescale 1ns/1ps
`default_nettype none
module adof_rx_model (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [6:0]  pair_data,
	input  wire logic        flag,
	input  wire logic        fclk,
	input  wire logic        inv,
	output logic      [13:0] word,
	output logic             lo_flag,
	output logic             hi_flag,
	output logic      [15:0] word_cnt
);
	logic       c_ff;
	logic       nc;
	logic [6:0] d_ff;
	logic [6:0] lo_ff;
	logic       f_ff;
	logic       lf_ff;
	// undo the invert so halves stay tied to data
	assign nc = fclk ^ inv;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			c_ff <= '0;
			d_ff <= '0;
			f_ff <= '0;
			lo_ff <= '0;
			lf_ff <= '0;
			word <= '0;
			lo_flag <= '0;
			hi_flag <= '0;
			word_cnt <= '0;
		end else begin
			c_ff <= nc;
			d_ff <= pair_data;
			f_ff <= flag;
			if (nc && !c_ff) begin
				lo_ff <= d_ff;
				lf_ff <= f_ff;
			end
			if (!nc && c_ff) begin
				for (int i = 0; i < 7; i++) begin
					word[2*i] <= lo_ff[i];
					word[2*i+1] <= d_ff[i];
				end
				lo_flag <= lf_ff;
				hi_flag <= f_ff;
				word_cnt <= word_cnt + 16'h1;
			end
		end
	end
endmodule
`default_nettype wire

// ===== verif/adof_top_tb.sv
// self-checking bench for the converter output formatter
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; $display("Error at %0t: got %h expected %h", $time, g, e); end end
module adof_top_tb;
	logic        aclk = '0, aresetn = '0, enc_clk = '0, rx_inv = '0;
	logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic        s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic [13:0] sample_code = '0, rx_word, w0;
	logic        sample_over = '0, sample_under = '0, par_mode_sel = '0, par_dcs_sel = '0;
	logic        par_sleep_sel = '0, par_low_current_sel = '0, f0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic [6:0]  ddr_pair_data;
	logic        ddr_pair_oe, range_flag, range_flag_oe, forwarded_out_clock, forwarded_out_clock_oe;
	logic        dcs_enable, sleep_active, nap_active, term_enable, data_settled, rx_lo_flag, rx_hi_flag;
	logic [7:0]  drive_current;
	logic [15:0] rx_cnt;
	logic [14:0] e;
	int          error_cnt = 0, samples_checked = 0, n;

	always #2 aclk = ~aclk;
	initial begin
		#5;
		forever #24 enc_clk = ~enc_clk;
	end

	adof_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .enc_clk, .sample_code,
		.sample_over, .sample_under, .par_mode_sel, .par_dcs_sel, .par_sleep_sel, .par_low_current_sel,
		.ddr_pair_data, .ddr_pair_oe, .range_flag, .range_flag_oe, .forwarded_out_clock, .forwarded_out_clock_oe,
		.dcs_enable, .sleep_active, .nap_active, .drive_current, .term_enable, .data_settled);
	adof_rx_model i_rx (.aclk, .aresetn, .pair_data(ddr_pair_data), .flag(range_flag), .fclk(forwarded_out_clock),
		.inv(rx_inv), .word(rx_word), .lo_flag(rx_lo_flag), .hi_flag(rx_hi_flag), .word_cnt(rx_cnt));

	task wr(input logic [9:0] idx, input logic [7:0] d);
		@(posedge aclk);
		n = 0;
		s_axi_awaddr <= {idx, 2'h0};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1 && n < 300);
		if (n >= 300) begin
			error_cnt++;
			$display("Error at %0t: write response timeout", $time);
		end
		resp = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask

	task rdr(input logic [9:0] idx);
		@(posedge aclk);
		n = 0;
		s_axi_araddr <= {idx, 2'h0};
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1 && n < 300);
		if (n >= 300) begin
			error_cnt++;
			$display("Error at %0t: read response timeout", $time);
		end
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask

	task words(input int k);
		logic [15:0] c0;
		c0 = rx_cnt;
		n = 0;
		while (16'(rx_cnt - c0) < k && n < 3000) begin
			@(posedge aclk);
			n++;
		end
		`CHK((n < 3000), 1'h1)
	endtask

	task smp(input logic [13:0] c, input logic o, input logic u);
		@(negedge enc_clk);
		@(posedge aclk);
		sample_code <= c;
		sample_over <= o;
		sample_under <= u;
		words(4);
	endtask

	function automatic logic [13:0] fmt(logic [13:0] c, logic [2:0] m);
		logic [13:0] w;
		w = c;
		if (m[0]) w = w ^ adof_pkg::MSB_MASK;
		if (m[1]) w = w ^ {{13{w[0]}}, 1'h0};
		if (m[2]) w = w ^ adof_pkg::ODD_MASK;
		return w;
	endfunction

	task t_regs;
		`CHK(drive_current, adof_pkg::CUR_3P5)
		`CHK(({ddr_pair_oe, range_flag_oe, forwarded_out_clock_oe}), 3'h7)
		for (int i = 1; i < 5; i++) begin
			rdr(10'(i));
			`CHK(rd, ({24'h0, adof_pkg::REG_RESET}))
		end
		rdr(10'h03F);
		`CHK(resp, adof_pkg::RESP_DECERR)
		wr(10'h03F, 8'hFF);
		`CHK(resp, adof_pkg::RESP_DECERR)
		wr(adof_pkg::IDX_DATA_FORMAT, 8'h13);
		rdr(adof_pkg::IDX_DATA_FORMAT);
		`CHK(rd, 32'h0000_0013)
		wr(adof_pkg::IDX_DATA_FORMAT, 8'h00);
		$display("test regs done");
	endtask

	task t_range;
		smp(14'h1000, 1'h1, 1'h0);
		`CHK(rx_word, adof_pkg::FULL_POS)
		`CHK(rx_lo_flag, 1'h1)
		`CHK(rx_hi_flag, 1'h0)
		smp(14'h1000, 1'h0, 1'h1);
		`CHK(rx_word, adof_pkg::FULL_NEG)
		`CHK(rx_lo_flag, 1'h1)
		smp(14'h1000, 1'h0, 1'h0);
		`CHK(({rx_lo_flag, rx_word}), 15'h1000)
		// status: period 12 aclk, settled, no nap, sleep or pin mode
		rdr(adof_pkg::IDX_STATUS);
		`CHK(rd, 32'h0000_0C08)
		$display("test range done");
	endtask

	task t_format;
		for (int m = 0; m < 8; m++) begin
			wr(adof_pkg::IDX_DATA_FORMAT, {3'h0, m[2], 2'h0, m[1], m[0]});
			smp(14'h1235, 1'h0, 1'h0);
			`CHK(rx_word, fmt(14'h1235, m[2:0]))
			`CHK(rx_lo_flag, 1'h0)
		end
		$display("test format done");
	endtask

	task t_pattern;
		for (int t = 0; t < 4; t++) begin
			wr(adof_pkg::IDX_DATA_FORMAT, {t[2:0], 5'h17});
			smp(14'h1235, 1'h0, 1'h0);
			w0 = rx_word;
			f0 = rx_lo_flag;
			words(1);
			e = (t == 0) ? '0 : (t == 1) ? '1 : (t == 2) ? (f0 ? {1'h1, adof_pkg::CHECK_A} :
				{1'h0, adof_pkg::CHECK_B}) : {15{f0}};
			`CHK(({f0, w0}), e)
			`CHK(({rx_lo_flag, rx_word}), ((t < 2) ? e : ~e))
		end
		wr(adof_pkg::IDX_DATA_FORMAT, 8'h00);
		$display("test pattern done");
	endtask

	task t_drive;
		logic [2:0] cd[7];
		logic [7:0] cu[7];
		cd = '{adof_pkg::ILVDS_3P5, adof_pkg::ILVDS_4P0, adof_pkg::ILVDS_4P5, adof_pkg::ILVDS_3P0,
			adof_pkg::ILVDS_2P5, adof_pkg::ILVDS_2P1, adof_pkg::ILVDS_1P75};
		cu = '{adof_pkg::CUR_3P5, adof_pkg::CUR_4P0, adof_pkg::CUR_4P5, adof_pkg::CUR_3P0,
			adof_pkg::CUR_2P5, adof_pkg::CUR_2P1, adof_pkg::CUR_1P75};
		for (int i = 0; i < 7; i++) begin
			wr(adof_pkg::IDX_OUTPUT_MODE, {3'h0, cd[i], 2'h0});
			@(posedge aclk);
			`CHK(drive_current, cu[i])
		end
		wr(adof_pkg::IDX_OUTPUT_MODE, {3'h0, adof_pkg::ILVDS_2P5, 2'h2});
		@(posedge aclk);
		`CHK(({term_enable, drive_current}), 9'h164)
		wr(adof_pkg::IDX_OUTPUT_MODE, 8'h01);
		repeat (2) @(posedge aclk);
		`CHK(({ddr_pair_oe, range_flag_oe, forwarded_out_clock_oe}), 3'h0)
		wr(adof_pkg::IDX_OUTPUT_MODE, 8'h00);
		repeat (2) @(posedge aclk);
		`CHK(({ddr_pair_oe, range_flag_oe, forwarded_out_clock_oe}), 3'h7)
		$display("test drive done");
	endtask

	task wake(output int k);
		k = 0;
		while (data_settled !== 1'h1 && k < 200) begin
			@(posedge enc_clk);
			k++;
		end
	endtask

	task t_power;
		int k;
		wr(adof_pkg::IDX_POWER_DOWN, 8'h08);
		@(posedge aclk);
		`CHK(sleep_active, 1'h1)
		wr(adof_pkg::IDX_POWER_DOWN, 8'h04);
		@(posedge aclk);
		`CHK(({sleep_active, nap_active, data_settled}), 3'h2)
		wr(adof_pkg::IDX_POWER_DOWN, 8'h00);
		wake(k);
		`CHK((k >= 100 && k <= 104), 1'h1)
		@(posedge aclk);
		par_mode_sel <= 1'h1;
		par_sleep_sel <= 1'h1;
		par_dcs_sel <= 1'h1;
		par_low_current_sel <= 1'h1;
		repeat (5) @(posedge aclk);
		`CHK(({sleep_active, dcs_enable}), 2'h3)
		`CHK(drive_current, adof_pkg::CUR_1P75)
		par_mode_sel <= 1'h0;
		par_sleep_sel <= 1'h0;
		par_dcs_sel <= 1'h0;
		par_low_current_sel <= 1'h0;
		repeat (5) @(posedge aclk);
		`CHK(sleep_active, 1'h0)
		wake(k);
		`CHK((k >= 100 && k <= 104), 1'h1)
		smp(14'h0ABC, 1'h0, 1'h0);
		`CHK(rx_word, 14'h0ABC)
		$display("test power done");
	endtask

	task dly(output int d);
		logic [6:0] p;
		n = 0;
		p = ddr_pair_data;
		@(posedge aclk);
		while (!(p === 7'h00 && ddr_pair_data === 7'h7F) && n < 100) begin
			p = ddr_pair_data;
			@(posedge aclk);
			n++;
		end
		d = 0;
		while (forwarded_out_clock !== 1'h1 && d < 12) begin
			@(posedge aclk);
			d++;
		end
	endtask

	task t_clock;
		int d;
		smp(14'h2AAA, 1'h0, 1'h0);
		for (int ph = 0; ph < 4; ph++) begin
			wr(adof_pkg::IDX_TIMING, {5'h0, ph[1:0], 1'h1});
			words(3);
			dly(d);
			`CHK(d, ph * 12 / 8)
		end
		wr(adof_pkg::IDX_TIMING, 8'h09);
		rx_inv <= 1'h1;
		words(3);
		`CHK(rx_word, 14'h2AAA)
		wr(adof_pkg::IDX_TIMING, 8'h00);
		rx_inv <= 1'h0;
		words(3);
		`CHK(rx_word, 14'h2AAA)
		$display("test clock done");
	endtask

	task complete_run;
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		#100000;
		error_cnt++;
		$display("Error at %0t: watchdog expired", $time);
		complete_run;
	end

	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (2) @(posedge aclk);
		t_regs;
		t_range;
		t_format;
		t_pattern;
		t_drive;
		t_power;
		t_clock;
		complete_run;
	end
endmodule
`default_nettype wire
